/* hw/see_params.svh */
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// Array size in bits, organised as bytes
`define SEE_MEM_BITS 2048
`define SEE_ADDR_W 8

// Device address word: fixed prefix, select bits, direction bit
`define SEE_DEV_PREFIX 4'ha
`define SEE_DEVICE_SELECT_BITS 3'h0
`define SEE_DIR_READ 1'b1

// Page geometry: low word-address bits that wrap inside a page
`define SEE_PAGE_BITS 3
`define SEE_PAGE_BYTES 8

// Bits per word on the bus
`define SEE_WORD_BITS 4'h8

// Self-timed programming cycle
`define SEE_CLK_MHZ 100
`define SEE_WR_TIME_NS 5000
`define SEE_WR_CYCLES ((`SEE_WR_TIME_NS * `SEE_CLK_MHZ + 999) / 1000)
`define SEE_TMR_W 16

`endif

/* hw/see_pkg.sv */
package see_pkg;

  typedef enum logic [3:0] {
    SEE_IDLE,
    SEE_DEV,
    SEE_ACK_DEV,
    SEE_WADDR,
    SEE_ACK_WADDR,
    SEE_WDATA,
    SEE_ACK_WDATA,
    SEE_RDATA,
    SEE_RACK
  } see_state_e;

  typedef logic [7:0] see_byte_t;

endpackage : see_pkg

/* hw/see_slave.sv */
// Function
// - Bus lines released while idle; pull-ups hold both high.
// - Driven data changes only while clock is low, stable while high.
// - Data fall with clock high is start; data rise with clock high is stop.
// - Words are eight bits; the receiver pulls data low to acknowledge each word.
// - Enter standby at power-up and after stop once internal work ends.
// - Device address word: one-zero prefix, select bits, direction bit last.
// - Select bits are zero, so only bus address 0x50 is answered.
// - Array holds 2 Kbit organised as bytes.
// - Byte write: device address, word address, one data byte, each acked, then stop.
// - Stop after write starts self-timed programming; inputs ignored until done.
// - Page write continues with up to seven more acked bytes, then stop.
// - Only the low three word-address bits increment during a page write.
// - More than eight bytes wrap and overwrite earlier bytes of the page.
// - Host polls with start and address; ack only once programming ends.
// - Address counter holds last address plus one; reads start there.
`timescale 1ns/1ps
`include "see_params.svh"

module see_slave
  import see_pkg::*;
#(
  parameter int unsigned WR_CYCLES = `SEE_WR_CYCLES,
  parameter int unsigned TMR_W = `SEE_TMR_W
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic standby_o,
  output logic write_busy_o
);

  localparam int unsigned MEM_BYTES = `SEE_MEM_BITS / 8;
  // Link-domain reset: asserted at once, released on the link clock
  logic lrst_s1_r;
  logic lrst_n_r;

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r <= lrst_s1_r;
    end
  end

  // Pin synchronisers; idle value high matches released lines
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  wire logic start_w = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire logic stop_w = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  wire logic scl_rise_w = scl_s2_r & ~scl_d_r;
  wire logic scl_fall_w = ~scl_s2_r & scl_d_r;

  // Programming-cycle handshake between the domains
  logic prog_tgl_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_tgl_r;

  // Busy while a commit toggle has not yet been echoed back
  wire logic busy_w = prog_tgl_r ^ done_s2_r;

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
    end
  end

  see_state_e state_r;
  see_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  see_byte_t shift_r;
  see_byte_t shift_nxt;
  see_byte_t tx_r;
  see_byte_t tx_nxt;
  logic [`SEE_ADDR_W-1:0] addr_r;
  logic [`SEE_ADDR_W-1:0] addr_nxt;
  logic oe_r;
  logic oe_nxt;
  logic nack_r;
  logic nack_nxt;
  logic [`SEE_PAGE_BYTES-1:0] valid_r;
  logic [`SEE_PAGE_BYTES-1:0] valid_nxt;
  logic buf_we;
  logic commit;
  logic standby_r;
  see_byte_t buf_r [`SEE_PAGE_BYTES];
  see_byte_t mem_r [MEM_BYTES];

  wire logic [`SEE_PAGE_BITS-1:0] slot_w = addr_r[`SEE_PAGE_BITS-1:0];
  wire logic [`SEE_PAGE_BITS-1:0] slot_inc_w = slot_w + 3'h1;
  wire logic [`SEE_ADDR_W-1:0] addr_inc_w = addr_r + 8'h01;
  wire see_byte_t rd_byte_w = mem_r[addr_r];
  wire logic addr_hit_w = shift_r[7:1] == {`SEE_DEV_PREFIX, `SEE_DEVICE_SELECT_BITS};
  wire logic word_done_w = cnt_r == `SEE_WORD_BITS;
  wire logic rx_state_w = state_r == SEE_DEV || state_r == SEE_WADDR || state_r == SEE_WDATA;
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    oe_nxt = oe_r;
    nack_nxt = nack_r;
    valid_nxt = valid_r;
    buf_we = 1'b0;
    commit = 1'b0;
    if (start_w) begin
      // Repeated start drops any uncommitted page data
      state_nxt = SEE_DEV;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      valid_nxt = '0;
    end else if (stop_w) begin
      state_nxt = SEE_IDLE;
      oe_nxt = 1'b0;
      commit = (|valid_r) & ~busy_w;
      valid_nxt = '0;
    end else begin
      if (scl_rise_w && rx_state_w) begin
        shift_nxt = {shift_r[6:0], sda_s2_r};
        cnt_nxt = cnt_r + 4'h1;
      end
      if (scl_rise_w && state_r == SEE_RDATA) begin
        cnt_nxt = cnt_r + 4'h1;
      end
      if (scl_rise_w && state_r == SEE_RACK) begin
        nack_nxt = sda_s2_r;
      end
      // All drive changes happen on a clock fall
      if (scl_fall_w) begin
        case (state_r)
          SEE_DEV: begin
            if (word_done_w) begin
              cnt_nxt = 4'h0;
              if (addr_hit_w && !busy_w) begin
                oe_nxt = 1'b1;
                state_nxt = SEE_ACK_DEV;
              end else begin
                state_nxt = SEE_IDLE;
              end
            end
          end
          SEE_ACK_DEV: begin
            if (shift_r[0] == `SEE_DIR_READ) begin
              tx_nxt = rd_byte_w;
              oe_nxt = ~rd_byte_w[7];
              state_nxt = SEE_RDATA;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = SEE_WADDR;
            end
          end
          SEE_WADDR: begin
            if (word_done_w) begin
              cnt_nxt = 4'h0;
              addr_nxt = shift_r;
              oe_nxt = 1'b1;
              state_nxt = SEE_ACK_WADDR;
            end
          end
          SEE_ACK_WADDR: begin
            oe_nxt = 1'b0;
            state_nxt = SEE_WDATA;
          end
          SEE_WDATA: begin
            if (word_done_w) begin
              cnt_nxt = 4'h0;
              buf_we = 1'b1;
              valid_nxt[slot_w] = 1'b1;
              addr_nxt = {addr_r[`SEE_ADDR_W-1:`SEE_PAGE_BITS], slot_inc_w};
              oe_nxt = 1'b1;
              state_nxt = SEE_ACK_WDATA;
            end
          end
          SEE_ACK_WDATA: begin
            oe_nxt = 1'b0;
            state_nxt = SEE_WDATA;
          end
          SEE_RDATA: begin
            if (word_done_w) begin
              cnt_nxt = 4'h0;
              oe_nxt = 1'b0;
              addr_nxt = addr_inc_w;
              state_nxt = SEE_RACK;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = ~tx_r[6];
            end
          end
          SEE_RACK: begin
            if (nack_r) begin
              state_nxt = SEE_IDLE;
            end else begin
              tx_nxt = rd_byte_w;
              oe_nxt = ~rd_byte_w[7];
              state_nxt = SEE_RDATA;
            end
          end
          default: oe_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      state_r <= SEE_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 8'h00;
      oe_r <= 1'b0;
      nack_r <= 1'b1;
      valid_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      oe_r <= oe_nxt;
      nack_r <= nack_nxt;
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      prog_tgl_r <= 1'b0;
      standby_r <= 1'b1;
    end else begin
      prog_tgl_r <= prog_tgl_r ^ commit;
      standby_r <= state_nxt == SEE_IDLE && !busy_w && !commit;
    end
  end

  // Page buffer: a wrapped slot simply takes the later byte
  for (genvar gi = 0; gi < `SEE_PAGE_BYTES; gi++) begin : g_buf
    always_ff @(posedge link_clk_i) begin
      if (buf_we && slot_w == 3'(gi)) begin
        buf_r[gi] <= shift_r;
      end
    end
  end

  // Nonvolatile array: no reset, contents survive the reset pin
  for (genvar gi = 0; gi < MEM_BYTES; gi++) begin : g_mem
    wire logic hit_w = commit && valid_r[gi % `SEE_PAGE_BYTES] &&
      addr_r[`SEE_ADDR_W-1:`SEE_PAGE_BITS] == 5'(gi / `SEE_PAGE_BYTES);
    always_ff @(posedge link_clk_i) begin
      if (hit_w) begin
        mem_r[gi] <= buf_r[gi % `SEE_PAGE_BYTES];
      end
    end
  end

  // Self-timed write cycle on the system clock
  logic prog_s1_r;
  logic prog_s2_r;
  logic prog_s3_r;
  logic run_r;
  logic [TMR_W-1:0] tmr_r;

  wire logic prog_ev_w = prog_s2_r ^ prog_s3_r;
  wire logic tmr_end_w = tmr_r == TMR_W'(WR_CYCLES - 1);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_s1_r <= 1'b0;
      prog_s2_r <= 1'b0;
      prog_s3_r <= 1'b0;
    end else begin
      prog_s1_r <= prog_tgl_r;
      prog_s2_r <= prog_s1_r;
      prog_s3_r <= prog_s2_r;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_r <= 1'b0;
      tmr_r <= '0;
      done_tgl_r <= 1'b0;
    end else if (prog_ev_w) begin
      run_r <= 1'b1;
      tmr_r <= '0;
    end else if (run_r) begin
      run_r <= !tmr_end_w;
      tmr_r <= tmr_r + TMR_W'(1);
      done_tgl_r <= done_tgl_r ^ tmr_end_w;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign standby_o = standby_r;
  assign write_busy_o = run_r;
endmodule : see_slave

/* verification/see_host_model.sv */
`timescale 1ns/1ps
module see_host_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // Phases of 200 ns keep every edge well apart at the link sampling rate
  task automatic ph(input logic s, input logic d);
    repeat (20) @(posedge clock_i);
    scl_low_o <= s;
    sda_low_o <= d;
  endtask : ph
  // Data moves only in the middle of the low phase
  task automatic bit_io(input logic b, output logic r);
    ph(1'b1, sda_low_o);
    ph(1'b1, !b);
    ph(1'b0, !b);
    repeat (10) @(posedge clock_i);
    r = sda_i;
  endtask : bit_io
  task automatic start();
    ph(1'b1, sda_low_o);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
    ph(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    ph(1'b1, sda_low_o);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
    ph(1'b0, 1'b0);
  endtask : stop
  // A low ack_in acknowledges a byte read from the memory
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : see_host_model

/* verification/see_slave_assertions.sv */
`timescale 1ns/1ps
module see_slave_assertions #(
  parameter int unsigned WR_CYCLES = 500
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic standby_o,
  input wire logic write_busy_o
);
  logic [15:0] busy_cnt_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 16'h0;
    end else begin
      busy_cnt_r <= write_busy_o ? busy_cnt_r + 16'h1 : 16'h0;
    end
  end
  AST_OPEN_DRAIN: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sda_oe_o |-> sda_o == 1'b0) else $error("data driven high");
  AST_IDLE_FREE: assert property (@(posedge clock_i) disable iff (!resetn_i)
    standby_o |-> !sda_oe_o) else $error("data pulled in standby");
  AST_SCL_LOW_CHG: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("data changed with clock high");
  AST_START_WAKE: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    scl_i && $fell(sda_i) |-> ##[1:6] !standby_o) else $error("start not seen");
  AST_ACK_HOLD: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    $rose(sda_oe_o) |=> sda_oe_o [*4]) else $error("pull too short");
  AST_BUSY_NO_STBY: assert property (@(posedge clock_i) disable iff (!resetn_i)
    write_busy_o |-> !standby_o) else $error("standby while busy");
  AST_BUSY_LEN: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(write_busy_o) |-> busy_cnt_r == 16'(WR_CYCLES)) else $error("busy length");
  AST_BUSY_NACK: assert property (@(posedge clock_i) disable iff (!resetn_i)
    write_busy_o |-> !sda_oe_o) else $error("answer while busy");
  AST_BUSY_END: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(write_busy_o) |-> ##[1:30] standby_o) else $error("no standby after busy");
endmodule : see_slave_assertions

bind see_slave see_slave_assertions #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .standby_o(standby_o), .write_busy_o(write_busy_o));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import see_pkg::*;
;
  localparam int unsigned WRC = 1000;
  logic clock_i, link_clk_i, resetn_i, scl_low, sda_low, scl_w, sda_w;
  logic sda_o, sda_oe_o, standby_o, write_busy_o, ak;
  see_byte_t rd;
  int n_errors = 0;
  int tests_run = 0;
  assign scl_w = !scl_low;
  assign sda_w = !(sda_low || sda_oe_o);
  see_slave #(.WR_CYCLES(WRC)) dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .link_clk_i(link_clk_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .standby_o(standby_o), .write_busy_o(write_busy_o));
  see_host_model u_host (.clock_i(clock_i), .sda_i(sda_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (write_busy_o !== v && k < 3000) begin
      @(posedge clock_i);
      k++;
    end
    chk({7'h0, write_busy_o}, {7'h0, v});
  endtask : wait_busy
  task automatic t_idle();
    chk({3'h0, sda_o, sda_oe_o, standby_o, scl_w, sda_w}, 8'h7);
  endtask : t_idle
  task automatic t_foreign();
    see_byte_t adr [2] = '{8'ha4, 8'he0};
    foreach (adr[i]) begin
      u_host.start();
      u_host.xfer(adr[i], 1'b1, rd, ak);
      chk({7'h0, ak}, 8'h1);
      u_host.stop();
    end
  endtask : t_foreign
  // Ten bytes from slot 6 wrap once into the page at 0x18
  task automatic t_page();
    u_host.start();
    u_host.xfer(8'ha0, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'h1e, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    for (int i = 0; i < 10; i++) begin
      u_host.xfer(8'h30 + 8'(i), 1'b1, rd, ak);
      chk({7'h0, ak}, 8'h0);
    end
    u_host.stop();
    wait_busy(1'b1);
    chk({7'h0, standby_o}, 8'h0);
    u_host.start();
    u_host.xfer(8'ha0, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h1);
    u_host.stop();
    wait_busy(1'b0);
    repeat (40) @(posedge clock_i);
    chk({7'h0, standby_o}, 8'h1);
  endtask : t_page
  task automatic t_rand_read();
    u_host.start();
    u_host.xfer(8'ha0, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'h18, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.start();
    u_host.xfer(8'ha1, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    for (int i = 0; i < 7; i++) begin
      u_host.xfer(8'hff, i == 6, rd, ak);
      chk(rd, (i < 6) ? 8'h32 + 8'(i) : 8'h38);
    end
    u_host.stop();
  endtask : t_rand_read
  task automatic t_cur_read();
    u_host.start();
    u_host.xfer(8'ha1, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'hff, 1'b1, rd, ak);
    chk(rd, 8'h39);
    u_host.stop();
  endtask : t_cur_read
  // One byte near the top of the array, read back at random
  task automatic t_byte();
    u_host.start();
    u_host.xfer(8'ha0, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'hf3, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'h5a, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (40) @(posedge clock_i);
    u_host.start();
    u_host.xfer(8'ha0, 1'b1, rd, ak);
    u_host.xfer(8'hf3, 1'b1, rd, ak);
    u_host.start();
    u_host.xfer(8'ha1, 1'b1, rd, ak);
    chk({7'h0, ak}, 8'h0);
    u_host.xfer(8'hff, 1'b1, rd, ak);
    chk(rd, 8'h5a);
    u_host.stop();
  endtask : t_byte
  initial begin
    resetn_i = 1'b0;
    repeat (2) @(posedge link_clk_i);
    @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    t_idle();
    t_foreign();
    t_page();
    t_rand_read();
    t_cur_read();
    t_byte();
    finish_test();
  end
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
